// *** rtl/jird_cfg.svh ***
// constants for the instruction register and decoder block
// assumes inclusion by bare name from the package and the rtl modules
`ifndef JIRD_CFG_SVH
`define JIRD_CFG_SVH

`define JIRD_IR_LEN_SHORT   8
`define JIRD_IR_LEN_LONG    16

// opcodes, long form; the short variant uses the low byte
`define JIRD_OP_SAMPLE      16'h0001
`define JIRD_OP_EXTEST      16'h0000
`define JIRD_OP_CLAMP       16'h00fa
`define JIRD_OP_HIGHZ       16'h00fc
`define JIRD_OP_IDCODE      16'h00fe
`define JIRD_OP_USERCODE    16'h00fd
`define JIRD_OP_CONFIG      16'h00ee

// capture pattern fixed fields
`define JIRD_CAP_LSBS       2'h1
`define JIRD_ERR_OK         2'h2
`define JIRD_ERR_FAIL       2'h1

// timing
`define JIRD_CLK_PERIOD_NS  100
`define JIRD_CF_LOW_NS      300
`define JIRD_CF_LOW_CYC \
  ((`JIRD_CF_LOW_NS + `JIRD_CLK_PERIOD_NS - 1) / `JIRD_CLK_PERIOD_NS)

`define JIRD_SYNC_STAGES    2

`endif

// *** rtl/jird_cfgpulse.sv ***
// configuration start pulse generator, system clock domain
// assumes i_tgl is already synchronised; each edge is one request
`timescale 1ns/100ps
`default_nettype none
`include "jird_cfg.svh"

module jird_cfgpulse
  import jird_pkg::*;
#(
  parameter int LOW_CYC = `JIRD_CF_LOW_CYC
) (
  input  wire logic i_clock,
  input  wire logic i_rst_n,
  input  wire logic i_tgl,
  output logic      o_start,
  output logic      o_load_n
);

  initial begin
    if (LOW_CYC < 1 || LOW_CYC > 255) begin
      $error("jird_cfgpulse: LOW_CYC out of range");
    end
  end

  logic       tgl_q;
  logic [7:0] cnt_q;
  logic [7:0] cnt_d;
  logic       start_q;
  logic       load_n_q;
  wire        req = i_tgl ^ tgl_q;

  // a request during a pulse restarts it: still a single low pulse
  assign cnt_d = req ? 8'(LOW_CYC) : (cnt_q != 8'h00 ? cnt_q - 8'h01 : 8'h00);

  always_ff @(posedge i_clock) begin
    if (!i_rst_n) begin
      tgl_q    <= 1'b0;
      cnt_q    <= 8'h00;
      start_q  <= 1'b0;
      load_n_q <= 1'b1;
    end else begin
      tgl_q    <= i_tgl;
      cnt_q    <= cnt_d;
      start_q  <= req;
      load_n_q <= (cnt_d == 8'h00);
    end
  end

  assign o_start  = start_q;
  assign o_load_n = load_n_q;

endmodule
`default_nettype wire

// *** rtl/jird_pkg.sv ***
// types shared by the instruction register and decoder block
// assumes the constants header is on the include path
`include "jird_cfg.svh"

package jird_pkg;

  typedef enum logic [3:0] {
    JIRD_TLR     = 4'h0,
    JIRD_IDLE    = 4'h1,
    JIRD_SEL_DR  = 4'h2,
    JIRD_CAP_DR  = 4'h3,
    JIRD_SH_DR   = 4'h4,
    JIRD_EX1_DR  = 4'h5,
    JIRD_PAU_DR  = 4'h6,
    JIRD_EX2_DR  = 4'h7,
    JIRD_UPD_DR  = 4'h8,
    JIRD_SEL_IR  = 4'h9,
    JIRD_CAP_IR  = 4'ha,
    JIRD_SH_IR   = 4'hb,
    JIRD_EX1_IR  = 4'hc,
    JIRD_PAU_IR  = 4'hd,
    JIRD_EX2_IR  = 4'he,
    JIRD_UPD_IR  = 4'hf
  } jird_tap_t;

  // device status, system clock domain, crossed to the test clock
  typedef struct packed {
    logic insys_cfg_mode;
    logic read_secure;
    logic isc_ok;
    logic erase_prog_ok;
    logic erase_prog_op;
    logic rev_done;
  } jird_status_t;

  // one-hot selection decoded from the active instruction
  typedef struct packed {
    logic bypass;
    logic sample;
    logic extest;
    logic clamp;
    logic highz;
    logic idcode;
    logic usercode;
    logic config_start;
  } jird_sel_t;

endpackage

// *** rtl/jird_sync.sv ***
// multi-bit two-flop level synchroniser
// assumes each bit is a quasi-static level or a toggle
`timescale 1ns/100ps
`default_nettype none
`include "jird_cfg.svh"

module jird_sync
  import jird_pkg::*;
#(
  parameter int WIDTH = 1
) (
  input  wire logic             i_clock,
  input  wire logic             i_rst_n,
  input  wire logic [WIDTH-1:0] i_async,
  output logic      [WIDTH-1:0] o_sync
);

  initial begin
    if (WIDTH < 1) begin
      $error("jird_sync: WIDTH must be at least 1");
    end
  end

  // first stage is read only by the second
  logic [WIDTH-1:0] meta_q;
  logic [WIDTH-1:0] sync_q;

  always_ff @(posedge i_clock) begin
    if (!i_rst_n) begin
      meta_q <= '0;
      sync_q <= '0;
    end else begin
      meta_q <= i_async;
      sync_q <= meta_q;
    end
  end

  assign o_sync = sync_q;

endmodule
`default_nettype wire

// *** rtl/jird_top.sv ***
// test access port, instruction register and instruction decoder
// assumes the host drives tck/tms/tdi; data registers sit outside
`timescale 1ns/100ps
`default_nettype none
`include "jird_cfg.svh"

module jird_top
  import jird_pkg::*;
#(
  parameter int IR_LEN = `JIRD_IR_LEN_SHORT,
  parameter int CF_CYC = `JIRD_CF_LOW_CYC
) (
  input  wire logic              i_clock,
  input  wire logic              i_rst_n,
  // test access port, link clock domain
  input  wire logic              i_tck,
  input  wire logic              i_tms,
  input  wire logic              i_tdi,
  input  wire logic              i_dr_tdo,
  output logic                   o_tdo,
  output logic                   o_tdo_oe,
  output logic                   o_shift_dr,
  output logic                   o_capture_dr,
  output logic                   o_update_dr,
  output jird_sel_t              o_dr_sel,
  output logic      [IR_LEN-1:0] o_instr_reg,
  // device status, system clock domain
  input  wire logic              i_insys_cfg_mode,
  input  wire logic              i_read_secure,
  input  wire logic              i_isc_ok,
  input  wire logic              i_erase_prog_ok,
  input  wire logic              i_erase_prog_op,
  input  wire logic              i_rev_done,
  input  wire logic        [1:0] i_revision_pick_pins,
  input  wire logic        [1:0] i_rev_bits,
  input  wire logic              i_rev_use_pins,
  // system side results
  output jird_sel_t              o_sys_sel,
  output logic                   o_fpga_load_pin_n,
  output logic                   o_rev_reset,
  output logic             [1:0] o_revision_pick_pins,
  output logic                   o_chain_enable_out,
  output logic                   o_outputs_float,
  output logic                   o_outputs_clamp,
  output logic                   o_read_inhibit
);

  localparam int ST_W = $bits(jird_status_t);
  localparam int SL_W = $bits(jird_sel_t);
  localparam logic [IR_LEN-1:0] RST_INSTR = IR_LEN'(`JIRD_OP_IDCODE);

  initial begin
    if (IR_LEN != `JIRD_IR_LEN_SHORT && IR_LEN != `JIRD_IR_LEN_LONG) begin
      $error("jird_top: IR_LEN must be 8 or 16");
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // functions

  function automatic jird_tap_t tap_next(input jird_tap_t s,
                                         input logic      tms);
    jird_tap_t n;
    n = JIRD_TLR;
    case (s)
      JIRD_TLR:    n = tms ? JIRD_TLR    : JIRD_IDLE;
      JIRD_IDLE:   n = tms ? JIRD_SEL_DR : JIRD_IDLE;
      JIRD_SEL_DR: n = tms ? JIRD_SEL_IR : JIRD_CAP_DR;
      JIRD_CAP_DR: n = tms ? JIRD_EX1_DR : JIRD_SH_DR;
      JIRD_SH_DR:  n = tms ? JIRD_EX1_DR : JIRD_SH_DR;
      JIRD_EX1_DR: n = tms ? JIRD_UPD_DR : JIRD_PAU_DR;
      JIRD_PAU_DR: n = tms ? JIRD_EX2_DR : JIRD_PAU_DR;
      JIRD_EX2_DR: n = tms ? JIRD_UPD_DR : JIRD_SH_DR;
      JIRD_UPD_DR: n = tms ? JIRD_SEL_DR : JIRD_IDLE;
      JIRD_SEL_IR: n = tms ? JIRD_TLR    : JIRD_CAP_IR;
      JIRD_CAP_IR: n = tms ? JIRD_EX1_IR : JIRD_SH_IR;
      JIRD_SH_IR:  n = tms ? JIRD_EX1_IR : JIRD_SH_IR;
      JIRD_EX1_IR: n = tms ? JIRD_UPD_IR : JIRD_PAU_IR;
      JIRD_PAU_IR: n = tms ? JIRD_EX2_IR : JIRD_PAU_IR;
      JIRD_EX2_IR: n = tms ? JIRD_UPD_IR : JIRD_SH_IR;
      JIRD_UPD_IR: n = tms ? JIRD_SEL_DR : JIRD_IDLE;
      default:     n = JIRD_TLR;
    endcase
    return n;
  endfunction

  function automatic logic [1:0] err_field(input logic ok);
    return ok ? `JIRD_ERR_OK : `JIRD_ERR_FAIL;
  endfunction

  function automatic logic [IR_LEN-1:0] capture(input jird_status_t st);
    logic [15:0] p;
    p = 16'h0000;
    if (IR_LEN == `JIRD_IR_LEN_SHORT) begin
      p[4]   = st.insys_cfg_mode;
      p[3]   = st.read_secure;
      p[1:0] = `JIRD_CAP_LSBS;
    end else begin
      p[8:7] = err_field(st.isc_ok);
      p[6:5] = err_field(st.erase_prog_ok);
      p[4]   = st.erase_prog_op;
      p[3]   = st.insys_cfg_mode;
      p[2]   = st.rev_done;
      p[1:0] = `JIRD_CAP_LSBS;
    end
    return p[IR_LEN-1:0];
  endfunction

  function automatic logic is_op(input logic [IR_LEN-1:0] ir,
                                 input logic [15:0]       op);
    return ir == op[IR_LEN-1:0];
  endfunction

  function automatic jird_sel_t decode(input logic [IR_LEN-1:0] ir);
    jird_sel_t s;
    s = '0;
    s.sample       = is_op(ir, `JIRD_OP_SAMPLE);
    s.extest       = is_op(ir, `JIRD_OP_EXTEST);
    s.clamp        = is_op(ir, `JIRD_OP_CLAMP);
    s.highz        = is_op(ir, `JIRD_OP_HIGHZ);
    s.idcode       = is_op(ir, `JIRD_OP_IDCODE);
    s.usercode     = is_op(ir, `JIRD_OP_USERCODE);
    s.config_start = is_op(ir, `JIRD_OP_CONFIG);
    // all-ones and anything unrecognised fall to bypass
    s.bypass       = (s == '0);
    return s;
  endfunction

  ////////////////////////////////////////////////////////////////////////
  // reset and status into the test clock domain

  // test logic still needs the system reset; tck may stop between scans
  logic              rst_tck_n;
  jird_status_t      stat_sys;
  logic [ST_W-1:0]   stat_tck_bits;
  jird_status_t      stat_tck;

  jird_sync #(
    .WIDTH (1)
  ) u_rst_sync (
    .i_clock (i_tck),
    .i_rst_n (1'b1),
    .i_async (i_rst_n),
    .o_sync  (rst_tck_n)
  );

  assign stat_sys.insys_cfg_mode = i_insys_cfg_mode;
  assign stat_sys.read_secure    = i_read_secure;
  assign stat_sys.isc_ok         = i_isc_ok;
  assign stat_sys.erase_prog_ok  = i_erase_prog_ok;
  assign stat_sys.erase_prog_op  = i_erase_prog_op;
  assign stat_sys.rev_done       = i_rev_done;

  // levels only; a field changing mid-capture may show old or new value
  jird_sync #(
    .WIDTH (ST_W)
  ) u_stat_sync (
    .i_clock (i_tck),
    .i_rst_n (rst_tck_n),
    .i_async (stat_sys),
    .o_sync  (stat_tck_bits)
  );

  assign stat_tck = jird_status_t'(stat_tck_bits);

  ////////////////////////////////////////////////////////////////////////
  // tap controller, instruction register

  jird_tap_t         tap_q;
  jird_tap_t         tap_d;
  logic [IR_LEN-1:0] ir_sh_q;
  logic [IR_LEN-1:0] ir_sh_d;
  logic [IR_LEN-1:0] instr_q;
  jird_sel_t         sel_q;
  logic              cfg_tgl_q;
  logic              tdo_q;
  logic              tdo_oe_q;

  wire in_tlr    = (tap_q == JIRD_TLR);
  wire in_cap_ir = (tap_q == JIRD_CAP_IR);
  wire in_sh_ir  = (tap_q == JIRD_SH_IR);
  wire in_upd_ir = (tap_q == JIRD_UPD_IR);
  wire in_sh_dr  = (tap_q == JIRD_SH_DR);
  wire new_cfg   = is_op(ir_sh_q, `JIRD_OP_CONFIG);

  assign tap_d = tap_next(tap_q, i_tms);

  assign ir_sh_d = in_cap_ir ? capture(stat_tck) :
                   in_sh_ir  ? {i_tdi, ir_sh_q[IR_LEN-1:1]} :
                               ir_sh_q;

  always_ff @(posedge i_tck) begin
    if (!rst_tck_n) begin
      tap_q <= JIRD_TLR;
    end else begin
      tap_q <= tap_d;
    end
  end

  always_ff @(posedge i_tck) begin
    if (!rst_tck_n) begin
      ir_sh_q <= '0;
    end else begin
      ir_sh_q <= ir_sh_d;
    end
  end

  always_ff @(posedge i_tck) begin
    if (!rst_tck_n || in_tlr) begin
      instr_q <= RST_INSTR;
      sel_q   <= decode(RST_INSTR);
    end else if (in_upd_ir) begin
      instr_q <= ir_sh_q;
      sel_q   <= decode(ir_sh_q);
    end
  end

  // one toggle per config update: exactly one load pulse downstream
  always_ff @(posedge i_tck) begin
    if (!rst_tck_n) begin
      cfg_tgl_q <= 1'b0;
    end else if (in_upd_ir && new_cfg) begin
      cfg_tgl_q <= ~cfg_tgl_q;
    end
  end

  // tdo changes on the falling edge so the host samples a stable bit
  always_ff @(negedge i_tck) begin
    if (!rst_tck_n) begin
      tdo_q    <= 1'b0;
      tdo_oe_q <= 1'b0;
    end else begin
      tdo_q    <= in_sh_ir ? ir_sh_q[0] : i_dr_tdo;
      tdo_oe_q <= in_sh_ir | in_sh_dr;
    end
  end

  assign o_tdo        = tdo_q;
  assign o_tdo_oe     = tdo_oe_q;
  assign o_shift_dr   = in_sh_dr;
  assign o_capture_dr = (tap_q == JIRD_CAP_DR);
  assign o_update_dr  = (tap_q == JIRD_UPD_DR);
  assign o_dr_sel     = sel_q;
  assign o_instr_reg  = instr_q;

  ////////////////////////////////////////////////////////////////////////
  // selection and config request into the system clock domain

  logic [SL_W-1:0] sel_sys_bits;
  jird_sel_t       sel_sys;
  logic            cfg_tgl_sys;
  logic      [1:0] rev_pins_sys;
  logic            cfg_start;
  logic            load_n;

  jird_sync #(
    .WIDTH (SL_W)
  ) u_sel_sync (
    .i_clock (i_clock),
    .i_rst_n (i_rst_n),
    .i_async (sel_q),
    .o_sync  (sel_sys_bits)
  );

  assign sel_sys = jird_sel_t'(sel_sys_bits);

  jird_sync #(
    .WIDTH (1)
  ) u_cfg_sync (
    .i_clock (i_clock),
    .i_rst_n (i_rst_n),
    .i_async (cfg_tgl_q),
    .o_sync  (cfg_tgl_sys)
  );

  jird_sync #(
    .WIDTH (2)
  ) u_pin_sync (
    .i_clock (i_clock),
    .i_rst_n (i_rst_n),
    .i_async (i_revision_pick_pins),
    .o_sync  (rev_pins_sys)
  );

  jird_cfgpulse #(
    .LOW_CYC (CF_CYC)
  ) u_cfgpulse (
    .i_clock  (i_clock),
    .i_rst_n  (i_rst_n),
    .i_tgl    (cfg_tgl_sys),
    .o_start  (cfg_start),
    .o_load_n (load_n)
  );

  ////////////////////////////////////////////////////////////////////////
  // system side outputs

  localparam logic HAS_REV = (IR_LEN == `JIRD_IR_LEN_LONG);

  wire [1:0] rev_pick  = i_rev_use_pins ? rev_pins_sys : i_rev_bits;
  // float on high-z, and in programming mode unless clamp holds them
  wire float_d = sel_sys.highz |
                 (i_insys_cfg_mode & ~sel_sys.clamp);

  jird_sel_t  sys_sel_q;
  logic       rev_reset_q;
  logic [1:0] revision_pick_pins_q;
  logic       chain_q;
  logic       float_q;
  logic       clamp_q;
  logic       rd_inh_q;

  always_ff @(posedge i_clock) begin
    if (!i_rst_n) begin
      sys_sel_q <= '0;
      chain_q   <= 1'b0;
      float_q   <= 1'b0;
      clamp_q   <= 1'b0;
      rd_inh_q  <= 1'b0;
    end else begin
      sys_sel_q <= sel_sys;
      chain_q   <= i_insys_cfg_mode;
      float_q   <= float_d;
      clamp_q   <= sel_sys.clamp;
      // only reads are gated; erase and program stay open
      rd_inh_q  <= i_read_secure;
    end
  end

  always_ff @(posedge i_clock) begin
    if (!i_rst_n) begin
      rev_reset_q <= 1'b0;
      revision_pick_pins_q   <= 2'h0;
    end else begin
      rev_reset_q <= cfg_start & HAS_REV;
      if (cfg_start && HAS_REV) begin
        revision_pick_pins_q <= rev_pick;
      end
    end
  end

  assign o_sys_sel          = sys_sel_q;
  assign o_fpga_load_pin_n  = load_n;
  assign o_rev_reset        = rev_reset_q;
  assign o_revision_pick_pins          = revision_pick_pins_q;
  assign o_chain_enable_out = chain_q;
  assign o_outputs_float    = float_q;
  assign o_outputs_clamp    = clamp_q;
  assign o_read_inhibit     = rd_inh_q;

endmodule
`default_nettype wire

// *** tb/jird_host_model.sv ***
// behavioural boundary-scan host that makes the test clock
// assumes the bench pulls the test data out up when not driven
`timescale 1ns/100ps
`default_nettype none

module jird_host_model #(
  parameter int N = 8
) (
  output logic      o_tck,
  output logic      o_tms,
  output logic      o_tdi,
  input  wire logic i_tdo
);
  logic [N-1:0] cap;
  event         done;

  initial begin
    o_tck = 1'b0;
    o_tms = 1'b1;
    o_tdi = 1'b0;
  end

  // clock stands still between steps; changes land after the falling edge
  task automatic step(input logic tms, input logic tdi, output logic tdo);
    o_tms = tms;
    o_tdi = tdi;
    #3 o_tck = 1'b1;
    tdo = i_tdo;
    #3 o_tck = 1'b0;
  endtask

  // idle data toggles so a stale level is never mistaken for data
  task automatic run(input int n, input logic tms);
    logic d;
    repeat (n) step(tms, ~o_tdi, d);
  endtask

  task automatic ir_scan(input logic [N-1:0] op);
    logic d;
    run(2, 1'b1);
    run(2, 1'b0);
    for (int i = 0; i < N; i++) begin
      step(i == N - 1, op[i], d);
      cap[i] = d;
    end
    run(1, 1'b1);
    run(1, 1'b0);
    ->done;
  endtask

  task automatic tap_reset();
    run(5, 1'b1);
    run(1, 1'b0);
    ->done;
  endtask
endmodule
`default_nettype wire

// *** tb/jird_top_asserts.sv ***
// checker for the instruction register block, both clock domains
// assumes it is bound onto jird_top with the parameters handed on
`timescale 1ns/100ps
`default_nettype none
`include "jird_cfg.svh"

module jird_top_asserts
  import jird_pkg::*;
#(
  parameter int IR_LEN = 8,
  parameter int CF_CYC = 3
) (
  input wire logic              i_clock,
  input wire logic              i_rst_n,
  input wire logic              i_tck,
  input wire logic              i_insys_cfg_mode,
  input wire logic              i_read_secure,
  input wire jird_sel_t         o_dr_sel,
  input wire logic [IR_LEN-1:0] o_instr_reg,
  input wire jird_sel_t         o_sys_sel,
  input wire logic              o_fpga_load_pin_n,
  input wire logic              o_chain_enable_out,
  input wire logic              o_outputs_float,
  input wire logic              o_outputs_clamp,
  input wire logic              o_read_inhibit
);
  logic [7:0]  low_cnt_q;
  logic [7:0]  low_cnt_d;
  wire  [15:0] ir16 = 16'(o_instr_reg);
  wire         known = ir16 inside {`JIRD_OP_SAMPLE, `JIRD_OP_EXTEST,
                 `JIRD_OP_CLAMP, `JIRD_OP_HIGHZ, `JIRD_OP_IDCODE,
                 `JIRD_OP_USERCODE, `JIRD_OP_CONFIG};

  // saturates so a stuck-low output cannot wrap to a legal count
  assign low_cnt_d = o_fpga_load_pin_n ? 8'h00 :
                     (low_cnt_q == 8'hff) ? low_cnt_q : low_cnt_q + 8'h01;

  always_ff @(posedge i_clock) begin
    if (!i_rst_n) low_cnt_q <= 8'h00;
    else low_cnt_q <= low_cnt_d;
  end

  ////////////////////////////////////////////////////////////////////////////
  sequence s_cfg_req;
    $rose(o_sys_sel.config_start);
  endsequence
  sequence s_load_low;
    !o_fpga_load_pin_n;
  endsequence
  sequence s_pulse_end;
    o_fpga_load_pin_n && !$past(o_fpga_load_pin_n);
  endsequence

  AST_LOAD_START: assert property (@(posedge i_clock) disable iff (!i_rst_n)
    s_cfg_req |-> ##[0:3] s_load_low) else $error("load pulse missing");
  AST_LOAD_LEN: assert property (@(posedge i_clock) disable iff (!i_rst_n)
    s_pulse_end |-> low_cnt_q == CF_CYC) else $error("load pulse length");
  AST_CHAIN_EN: assert property (@(posedge i_clock) disable iff (!i_rst_n)
    i_insys_cfg_mode |=> o_chain_enable_out) else $error("chain enable low");
  AST_READ_INH: assert property (@(posedge i_clock) disable iff (!i_rst_n)
    i_read_secure |=> o_read_inhibit) else $error("read not inhibited");
  AST_FLOAT_HIGHZ: assert property (@(posedge i_clock) disable iff (!i_rst_n)
    o_sys_sel.highz [*3] |-> o_outputs_float) else $error("highz not float");
  AST_FLOAT_ISC: assert property (@(posedge i_clock) disable iff (!i_rst_n)
    (i_insys_cfg_mode && !o_sys_sel.clamp) [*3] |-> o_outputs_float)
    else $error("insys outputs not float");
  AST_CLAMP_OUT: assert property (@(posedge i_clock) disable iff (!i_rst_n)
    o_sys_sel.clamp [*3] |-> o_outputs_clamp && !o_outputs_float)
    else $error("clamp not held");
  AST_SEL_ONEHOT: assert property (@(posedge i_tck) disable iff (!i_rst_n)
    $onehot(o_dr_sel)) else $error("selection not one-hot");
  AST_UNKNOWN_BYP: assert property (@(posedge i_tck) disable iff (!i_rst_n)
    !known |-> o_dr_sel.bypass) else $error("unknown opcode not bypass");
  AST_DEC_STD: assert property (@(posedge i_tck) disable iff (!i_rst_n)
    o_dr_sel.sample == (ir16 == `JIRD_OP_SAMPLE) &&
    o_dr_sel.extest == (ir16 == `JIRD_OP_EXTEST)) else $error("std decode");
  AST_DEC_OPT: assert property (@(posedge i_tck) disable iff (!i_rst_n)
    o_dr_sel.clamp == (ir16 == `JIRD_OP_CLAMP) &&
    o_dr_sel.highz == (ir16 == `JIRD_OP_HIGHZ) &&
    o_dr_sel.usercode == (ir16 == `JIRD_OP_USERCODE))
    else $error("optional decode");
endmodule

bind jird_top jird_top_asserts #(.IR_LEN(IR_LEN), .CF_CYC(CF_CYC))
  jird_top_asserts_i (.i_clock, .i_rst_n, .i_tck, .i_insys_cfg_mode,
  .i_read_secure, .o_dr_sel, .o_instr_reg, .o_sys_sel, .o_fpga_load_pin_n,
  .o_chain_enable_out, .o_outputs_float, .o_outputs_clamp, .o_read_inhibit);
`default_nettype wire

// *** tb/tb_jird_top.sv ***
// self-checking bench for the instruction register block, short variant
// assumes the rtl package, the host model and the checker are compiled
`timescale 1ns/100ps
`default_nettype none
`include "jird_cfg.svh"

module tb_jird_top
  import jird_pkg::*;
;
  localparam int N = 8;
  localparam int CF = 3;
  typedef struct {logic [N-1:0] cap; jird_sel_t sel; bit has_cap;} jird_exp_t;

  logic       clk = 1'b0;
  logic       rst_n = 1'b0;
  logic       insys, rsec, isc_ok, ep_ok, ep_op, rdone, use_pins, dr_tdo;
  logic [1:0] pins, rbits;
  logic [7:0] ops [8] = '{8'hff, 8'h01, 8'h00, 8'hfa, 8'hfc, 8'hfe, 8'hfd,
                          8'hee};
  wire        tck, tms, tdi, tdo, tdo_oe, load_n;
  wire        tdo_w = tdo_oe ? tdo : 1'b1;
  wire jird_sel_t dr_sel;
  int         num_errors = 0;
  int         n_checks = 0;
  int         seed = 32'h7fd4a3d3;
  jird_exp_t  exp_q [$];
  jird_exp_t  e;
  int         pulse_q [$];

  jird_top #(.IR_LEN(N), .CF_CYC(CF)) jird_top_i (.i_clock(clk),
    .i_rst_n(rst_n), .i_tck(tck), .i_tms(tms), .i_tdi(tdi),
    .i_dr_tdo(dr_tdo), .o_tdo(tdo), .o_tdo_oe(tdo_oe), .o_shift_dr(),
    .o_capture_dr(), .o_update_dr(), .o_dr_sel(dr_sel), .o_instr_reg(),
    .i_insys_cfg_mode(insys), .i_read_secure(rsec), .i_isc_ok(isc_ok),
    .i_erase_prog_ok(ep_ok), .i_erase_prog_op(ep_op), .i_rev_done(rdone),
    .i_revision_pick_pins(pins), .i_rev_bits(rbits),
    .i_rev_use_pins(use_pins), .o_sys_sel(), .o_fpga_load_pin_n(load_n),
    .o_rev_reset(), .o_revision_pick_pins(), .o_chain_enable_out(),
    .o_outputs_float(), .o_outputs_clamp(), .o_read_inhibit());
  jird_host_model #(.N(N)) jird_host_model_i (.o_tck(tck), .o_tms(tms),
    .o_tdi(tdi), .i_tdo(tdo_w));

  always #50 clk = ~clk;

  ////////////////////////////////////////////////////////////////////////////
  task automatic fail(input string msg);
    num_errors++;
    $display("CHECK FAILED t=%0t %s", $time, msg);
  endtask
  task automatic chk_cap(input logic [N-1:0] got, input logic [N-1:0] xp);
    n_checks++;
    if (got !== xp) fail($sformatf("capture %h expected %h", got, xp));
  endtask
  task automatic chk_sel(input jird_sel_t got, input jird_sel_t xp);
    n_checks++;
    if (got !== xp) fail($sformatf("select %h expected %h", got, xp));
  endtask
  task automatic chk_cnt(input int got, input int xp, input string what);
    n_checks++;
    if (got != xp) fail($sformatf("%s %0d expected %0d", what, got, xp));
  endtask
  task automatic wrap_up();
    $display("checks %0d mismatches %0d", n_checks, num_errors);
    if (num_errors == 0 && n_checks > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  function automatic jird_sel_t dec(input logic [7:0] op);
    jird_sel_t s;
    s = '0;
    case (op)
      8'h01: s.sample = 1'b1;
      8'h00: s.extest = 1'b1;
      8'hfa: s.clamp = 1'b1;
      8'hfc: s.highz = 1'b1;
      8'hfe: s.idcode = 1'b1;
      8'hfd: s.usercode = 1'b1;
      8'hee: s.config_start = 1'b1;
      default: s.bypass = 1'b1;
    endcase
    return s;
  endfunction

  // status is set before the scan; its tck edges ahead of capture-ir let the crossing settle
  task automatic scan(input logic [7:0] op);
    logic [31:0] r;
    @(posedge clk) #1;
    r = $random(seed);
    {insys, rsec, isc_ok, ep_ok, ep_op, rdone} = r[5:0];
    {pins, rbits, use_pins} = r[10:6];
    repeat (2) @(posedge clk);
    exp_q.push_back('{{3'h0, insys, rsec, 1'b0, `JIRD_CAP_LSBS}, dec(op), 1});
    if (op == 8'hee) pulse_q.push_back(CF);
    jird_host_model_i.ir_scan(op);
    repeat (8) @(posedge clk);
  endtask

  ////////////////////////////////////////////////////////////////////////////
  always @(jird_host_model_i.done) begin
    if (exp_q.size() == 0) begin
      fail("unexpected scan result");
    end else begin
      e = exp_q.pop_front();
      if (e.has_cap) chk_cap(jird_host_model_i.cap, e.cap);
      chk_sel(dr_sel, e.sel);
    end
  end

  always @(negedge load_n) begin
    int n;
    n = 0;
    while (load_n === 1'b0 && n < 50) begin
      @(posedge clk) #1;
      n++;
    end
    if (pulse_q.size() == 0) fail("unexpected load pulse");
    else chk_cnt(n, pulse_q.pop_front(), "load pulse cycles");
    if (n == 50) wrap_up();
  end

  always @(posedge clk) #1 dr_tdo = 1'($random(seed));

  initial begin
    #100000;
    fail("timeout");
    wrap_up();
  end

  initial begin
    logic [7:0] op;
    {insys, rsec, isc_ok, ep_ok, ep_op, rdone, use_pins} = '0;
    pins = 2'h0;
    rbits = 2'h0;
    fork
      repeat (10) @(posedge clk);
      jird_host_model_i.run(30, 1'b1);
    join
    #1 rst_n = 1'b1;
    jird_host_model_i.run(8, 1'b1);
    jird_host_model_i.run(1, 1'b0);
    foreach (ops[i]) scan(ops[i]);
    repeat (3) begin
      do op = 8'($random(seed));
      while (op inside {8'h01, 8'h00, 8'hfa, 8'hfc, 8'hfe, 8'hfd, 8'hee});
      scan(op);
    end
    $display("test capture and decode done");
    scan(8'hee);
    scan(8'hfd);
    exp_q.push_back('{8'h00, dec(8'hfe), 0});
    jird_host_model_i.tap_reset();
    repeat (4) @(posedge clk);
    $display("test tap reset done");
    chk_cnt(pulse_q.size(), 0, "load pulses missing");
    chk_cnt(exp_q.size(), 0, "scan results missing");
    wrap_up();
  end
endmodule
`default_nettype wire
